// [src/touch_adc_pkg.sv]
// Shared constants, codes and state encoding for the touch ADC input control.
package touch_adc_pkg;
  // ==========================================================================
  // Types and state codes
  // ==========================================================================
  typedef logic [2:0] chan_t;
  typedef logic [1:0] ref_sel_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CTRL = 4'h2,
    ST_ACQ  = 4'h4,
    ST_CONV = 4'h8
  } conv_state_e;

  // ==========================================================================
  // Channel codes
  // ==========================================================================
  localparam chan_t CH_TEMP_LOW = 3'h0;
  localparam chan_t CH_Y_POS = 3'h1;
  localparam chan_t CH_BATTERY = 3'h2;
  localparam chan_t CH_PRESS_FIRST = 3'h3;
  localparam chan_t CH_PRESS_SECOND = 3'h4;
  localparam chan_t CH_X_POS = 3'h5;
  localparam chan_t CH_AUX = 3'h6;
  localparam chan_t CH_TEMP_HIGH = 3'h7;

  // ==========================================================================
  // Reference source codes
  // ==========================================================================
  localparam ref_sel_t REFP_VREF = 2'h0;
  localparam ref_sel_t REFP_YP = 2'h1;
  localparam ref_sel_t REFP_XP = 2'h2;
  localparam ref_sel_t REFN_GND = 2'h0;
  localparam ref_sel_t REFN_YN = 2'h1;
  localparam ref_sel_t REFN_XN = 2'h2;

  // ==========================================================================
  // Serial counts and reset values
  // ==========================================================================
  localparam logic [3:0] CTRL_FIRST_CNT = 4'h1;
  localparam logic [3:0] CTRL_MODE_CNT = 4'h4;
  localparam logic [3:0] ACQ_CLOCKS = 4'h3;
  localparam logic [3:0] CONV_CLOCKS_12 = 4'hC;
  localparam logic [3:0] CONV_CLOCKS_8 = 4'h8;
  localparam logic [3:0] RATIO_EXTRA_CLOCKS = 4'h1;
  localparam int FULL_SCALE_CODES = 4096;
  localparam chan_t RST_CHAN = 3'h0;
  localparam logic RST_SINGLE_ENDED = 1'b1;
  localparam logic RST_RES8 = 1'b0;
  localparam logic RST_INT_REF = 1'b0;
  localparam logic RST_KEEP_ON = 1'b0;
endpackage : touch_adc_pkg

// [src/touch_adc_input_mux_ref_control.sv]
// Input multiplexer, reference and panel driver control of a touch ADC.
`timescale 1ns/100ps
// Behaviour
// - Channel and reference-mode bits arrive serially on data input and steer config.
// - Single-ended codes pick temp, Y, battery, pressure, X, aux, temp with drivers.
// - Differential codes 001, 011/100, 101 use driven plates as references.
// - Hold captures positive minus negative input, then that value is converted.
// - Reference power bit one turns internal reference on, zero turns it off.
// - Reference-mode low ties reference inputs to the active driver pins.
// - In 12-bit mode one code step is reference span over 4096.
// - Acquire window lasts three serial clocks.
// - Keep-on bit one keeps drivers on between conversions and the converter powered while chip select stays low.
// - Overlapped conversions keep drivers on through the next control byte only with keep-on bit one.
// - Control byte MSB first: start, channel 2..0, resolution, ref mode, powers.
// - Acquire starts after resolution bit; three clocks later conversion starts.
// - Ratiometric conversion keeps drivers on and adds one clock (13 in 12-bit mode, 9 in 8-bit mode).
module touch_adc_input_mux_ref_control (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic serial_conv_clock_in,
  input wire logic din_in,
  input wire logic cs_n_in,
  output touch_adc_pkg::chan_t pos_input_sel_out,
  output touch_adc_pkg::ref_sel_t ref_pos_sel_out,
  output touch_adc_pkg::ref_sel_t ref_neg_sel_out,
  output logic drv_xp_out,
  output logic drv_xn_out,
  output logic drv_yp_out,
  output logic drv_yn_out,
  output logic acquire_out,
  output logic hold_out,
  output logic busy_out,
  output logic adc_on_out,
  output logic int_ref_on_out,
  output logic res8_out,
  output logic unsupported_out
);
  import touch_adc_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // The first stage feeds only the second; a clock or select level is taken once stages two
  // and three agree, which rejects a single-cycle glitch on those two pins.
  logic [2:0] sclk_s, din_s, csn_s;
  logic [2:0] next_sclk_s, next_din_s, next_csn_s;
  logic sclk_lvl, csn_lvl, next_sclk_lvl, next_csn_lvl;
  logic take, din_lvl;

  always_comb begin
    next_sclk_s = {sclk_s[1:0], serial_conv_clock_in};
    next_din_s = {din_s[1:0], din_in};
    next_csn_s = {csn_s[1:0], cs_n_in};
    next_sclk_lvl = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_lvl;
    next_csn_lvl = (csn_s[1] == csn_s[2]) ? csn_s[2] : csn_lvl;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sclk_s <= 3'h0;
      din_s <= 3'h0;
      csn_s <= 3'h7;
      sclk_lvl <= 1'b0;
      csn_lvl <= 1'b1;
    end else begin
      sclk_s <= next_sclk_s;
      din_s <= next_din_s;
      csn_s <= next_csn_s;
      sclk_lvl <= next_sclk_lvl;
      csn_lvl <= next_csn_lvl;
    end
  end

  assign take = (sclk_s[1] == sclk_s[2]) && sclk_s[2] && !sclk_lvl && !csn_lvl;
  assign din_lvl = din_s[2];

  // ==========================================================================
  // Control byte sequencer
  // ==========================================================================
  conv_state_e state, next_state;
  logic [3:0] cnt, next_cnt, conv_last;
  chan_t chan, next_chan;
  logic res8, ser, pd1, pd0;
  logic next_res8, next_ser, next_pd1, next_pd0;

  // The extra clock of a ratiometric conversion (13th at 12 bits, 9th at 8 bits) lengthens the hold phase.
  assign conv_last = (res8 ? CONV_CLOCKS_8 : CONV_CLOCKS_12)
                     + (ser ? 4'h0 : RATIO_EXTRA_CLOCKS) - 4'h1;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_chan = chan;
    next_res8 = res8;
    next_ser = ser;
    next_pd1 = pd1;
    next_pd0 = pd0;
    if (csn_lvl) begin
      next_state = ST_IDLE;
      next_cnt = 4'h0;
    end else if (take) begin
      unique case (state)
        ST_IDLE: begin
          if (din_lvl) begin
            next_state = ST_CTRL;
            next_cnt = CTRL_FIRST_CNT;
          end
        end
        ST_CTRL: begin
          next_cnt = cnt + 4'h1;
          if (cnt == CTRL_MODE_CNT) begin
            next_res8 = din_lvl;
            next_state = ST_ACQ;
            next_cnt = 4'h0;
          end else begin
            next_chan = {chan[1:0], din_lvl};
          end
        end
        ST_ACQ: begin
          next_cnt = cnt + 4'h1;
          unique case (cnt)
            4'h0: next_ser = din_lvl;
            4'h1: next_pd1 = din_lvl;
            default: next_pd0 = din_lvl;
          endcase
          if (cnt == ACQ_CLOCKS - 4'h1) begin
            next_state = ST_CONV;
            next_cnt = 4'h0;
          end
        end
        ST_CONV: begin
          if (din_lvl) begin
            next_state = ST_CTRL;
            next_cnt = CTRL_FIRST_CNT;
          end else if (cnt == conv_last) begin
            next_state = ST_IDLE;
            next_cnt = 4'h0;
          end else begin
            next_cnt = cnt + 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      chan <= RST_CHAN;
      res8 <= RST_RES8;
      ser <= RST_SINGLE_ENDED;
      pd1 <= RST_INT_REF;
      pd0 <= RST_KEEP_ON;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      chan <= next_chan;
      res8 <= next_res8;
      ser <= next_ser;
      pd1 <= next_pd1;
      pd0 <= next_pd0;
    end
  end

  // ==========================================================================
  // Multiplexer, reference and driver configuration
  // ==========================================================================
  logic [3:0] pat, next_drv;
  logic unsup, active;
  ref_sel_t refp, refn;

  always_comb begin
    pat = 4'h0;
    refp = REFP_VREF;
    refn = REFN_GND;
    unsup = 1'b0;
    unique case (chan)
      CH_Y_POS: begin
        pat = 4'h3;
        if (!ser) begin
          refp = REFP_YP;
          refn = REFN_YN;
        end
      end
      CH_PRESS_FIRST, CH_PRESS_SECOND: begin
        pat = 4'h6;
        if (!ser) begin
          refp = REFP_YP;
          refn = REFN_XN;
        end
      end
      CH_X_POS: begin
        pat = 4'hC;
        if (!ser) begin
          refp = REFP_XP;
          refn = REFN_XN;
        end
      end
      default: unsup = !ser;
    endcase
    // Single-ended drivers drop at hold, so the sample is taken loaded.
    active = (state == ST_ACQ) || ((state == ST_CONV) && !ser)
             || (((state == ST_IDLE) || (state == ST_CTRL)) && pd0);
    next_drv = (active && !unsup) ? pat : 4'h0;
  end

  // Bit order of next_drv: 3 X+, 2 X-, 1 Y+, 0 Y-.
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pos_input_sel_out <= RST_CHAN;
      ref_pos_sel_out <= REFP_VREF;
      ref_neg_sel_out <= REFN_GND;
      {drv_xp_out, drv_xn_out, drv_yp_out, drv_yn_out} <= 4'h0;
      acquire_out <= 1'b0;
      hold_out <= 1'b0;
      busy_out <= 1'b0;
      adc_on_out <= 1'b0;
      int_ref_on_out <= RST_INT_REF;
      res8_out <= RST_RES8;
      unsupported_out <= 1'b0;
    end else begin
      pos_input_sel_out <= chan;
      ref_pos_sel_out <= refp;
      ref_neg_sel_out <= refn;
      {drv_xp_out, drv_xn_out, drv_yp_out, drv_yn_out} <= next_drv;
      acquire_out <= (state == ST_ACQ);
      hold_out <= (state == ST_CONV);
      busy_out <= (state == ST_CONV);
      adc_on_out <= !csn_lvl && ((state != ST_IDLE) || pd0);
      int_ref_on_out <= pd1;
      res8_out <= res8;
      unsupported_out <= unsup;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_last_acq_bit;
    state == ST_ACQ && take && cnt == ACQ_CLOCKS - 4'h1;
  endsequence
  property p_acq_three;
    s_last_acq_bit |=> state == ST_CONV ##1 hold_out;
  endproperty
  a_acq_three: assert property (p_acq_three) else $error("acquire not three clocks");
  property p_acq_start;
    (state == ST_CTRL && take && cnt == CTRL_MODE_CNT) |=> state == ST_ACQ ##1 acquire_out;
  endproperty
  a_acq_start: assert property (p_acq_start) else $error("acquire late");
  property p_ref_power;
    (state == ST_ACQ && take && !csn_lvl && cnt == 4'h1)
      |=> ##1 int_ref_on_out == $past(din_lvl, 2);
  endproperty
  a_ref_power: assert property (p_ref_power) else $error("reference power wrong");
  property p_conv_end;
    (state == ST_CONV && take && !csn_lvl && !din_lvl && cnt == conv_last)
      |=> state == ST_IDLE ##1 !busy_out;
  endproperty
  a_conv_end: assert property (p_conv_end) else $error("conversion length wrong");
  property p_se_xpos;
    $past(state == ST_ACQ && ser && chan == CH_X_POS)
      |-> drv_xp_out && drv_xn_out && !drv_yp_out && !drv_yn_out;
  endproperty
  a_se_xpos: assert property (p_se_xpos) else $error("X drivers wrong");
  property p_diff_press;
    $past(!ser && chan == CH_PRESS_FIRST)
      |-> ref_pos_sel_out == REFP_YP && ref_neg_sel_out == REFN_XN;
  endproperty
  a_diff_press: assert property (p_diff_press) else $error("diff refs wrong");
  property p_ratio_hold;
    $past(state == ST_CONV && !ser && chan == CH_Y_POS) |-> drv_yp_out && drv_yn_out && hold_out;
  endproperty
  a_ratio_hold: assert property (p_ratio_hold) else $error("ratio drivers off");
  property p_se_hold_off;
    $past(state == ST_CONV && ser) |-> !drv_xp_out && !drv_yp_out && hold_out;
  endproperty
  a_se_hold_off: assert property (p_se_hold_off) else $error("drivers on at hold");
  property p_keep_on;
    $past(state == ST_IDLE && pd0 && chan == CH_X_POS && (ser || !unsup)) |-> drv_xp_out;
  endproperty
  a_keep_on: assert property (p_keep_on) else $error("keep-on drivers off");
  property p_unsup;
    $past(!ser && chan == CH_AUX) |-> unsupported_out && !drv_xp_out && !drv_yp_out;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported not flagged");
endmodule : touch_adc_input_mux_ref_control

// [tb/touch_host_model.sv]
// Host serial port model that clocks control bits into the touch ADC block.
`timescale 1ns/100ps
module touch_host_model (
  input wire logic core_clk_in,
  output logic sclk_out,
  output logic din_out,
  output logic cs_n_out
);
  // ==========================================================================
  // Serial bit driver
  // ==========================================================================
  initial begin
    sclk_out = 1'b0;
    din_out = 1'b0;
    cs_n_out = 1'b1;
  end

  // Each half period spans several core clocks so the synchroniser sees every edge.
  task automatic clk_bit(input logic b);
    @(posedge core_clk_in);
    #1;
    cs_n_out = 1'b0;
    din_out = b;
    repeat (5) @(posedge core_clk_in);
    #1;
    sclk_out = 1'b1;
    repeat (8) @(posedge core_clk_in);
    #1;
    sclk_out = 1'b0;
    // Data past its hold time shows the inverse, so a stale value cannot pass.
    din_out = ~b;
  endtask : clk_bit

  task automatic deselect();
    @(posedge core_clk_in);
    #1;
    cs_n_out = 1'b1;
  endtask : deselect
endmodule : touch_host_model

// [tb/tb_touch_adc_input_mux_ref_control.sv]
// Self-checking bench for the touch ADC input and reference control.
`timescale 1ns/100ps
module tb_touch_adc_input_mux_ref_control;
  import touch_adc_pkg::*;
  logic core_clk_in, rstn_in, sclk, din, cs_n;
  logic xp, xn, yp, yn, acq, hold, busy, adc_on, iref, res8, unsup;
  logic [3:0] drv;
  logic [7:0] ob;
  chan_t pos_sel;
  ref_sel_t refp, refn;
  int n_fail, tests_run, cycles;
  assign drv = {xp, xn, yp, yn};

  touch_host_model u_host (.core_clk_in(core_clk_in), .sclk_out(sclk), .din_out(din),
    .cs_n_out(cs_n));
  touch_adc_input_mux_ref_control u_dut (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .serial_conv_clock_in(sclk), .din_in(din), .cs_n_in(cs_n), .pos_input_sel_out(pos_sel),
    .ref_pos_sel_out(refp), .ref_neg_sel_out(refn), .drv_xp_out(xp), .drv_xn_out(xn),
    .drv_yp_out(yp), .drv_yn_out(yn), .acquire_out(acq), .hold_out(hold), .busy_out(busy),
    .adc_on_out(adc_on), .int_ref_on_out(iref), .res8_out(res8), .unsupported_out(unsup));

  // ==========================================================================
  // Clock, timeout and reporting
  // ==========================================================================
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic give_verdict();
    $display("compared %0d, failed %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // ==========================================================================
  // Expected configuration
  // ==========================================================================
  function automatic logic [3:0] drv_exp(input chan_t c);
    case (c)
      CH_Y_POS: return 4'h3;
      CH_PRESS_FIRST, CH_PRESS_SECOND: return 4'h6;
      CH_X_POS: return 4'hC;
      default: return 4'h0;
    endcase
  endfunction : drv_exp

  function automatic logic [3:0] ref_exp(input chan_t c, input logic se);
    if (se) return {REFP_VREF, REFN_GND};
    case (c)
      CH_Y_POS: return {REFP_YP, REFN_YN};
      CH_PRESS_FIRST, CH_PRESS_SECOND: return {REFP_YP, REFN_XN};
      CH_X_POS: return {REFP_XP, REFN_XN};
      default: return {REFP_VREF, REFN_GND};
    endcase
  endfunction : ref_exp

  // One full control byte followed by the whole conversion.
  task automatic conv(input chan_t c, input logic se, r8, pw, kp);
    logic [3:0] d;
    int n;
    d = drv_exp(c);
    n = (r8 ? 8 : 12) + (se ? 0 : 1);
    u_host.clk_bit(1'b1);
    for (int i = 2; i >= 0; i--) u_host.clk_bit(c[i]);
    u_host.clk_bit(r8);
    check(8'(acq), 8'h01);
    check(8'(res8), 8'(r8));
    u_host.clk_bit(se);
    check(8'(pos_sel), 8'(c));
    check(8'(drv), 8'(d));
    check(8'({refp, refn}), 8'(ref_exp(c, se)));
    check(8'(unsup), 8'(!se && d == 4'h0));
    u_host.clk_bit(pw);
    check(8'(iref), 8'(pw));
    u_host.clk_bit(kp);
    check(8'(acq), 8'h00);
    check(8'({hold, busy}), 8'h03);
    check(8'(drv), 8'(se ? 4'h0 : d));
    repeat (n - 1) u_host.clk_bit(1'b0);
    check(8'(hold), 8'h01);
    u_host.clk_bit(1'b0);
    check(8'(hold), 8'h00);
    check(8'(adc_on), 8'(kp));
    check(8'(drv), 8'(kp ? d : 4'h0));
  endtask : conv

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    rstn_in = 1'b0;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    repeat (10) @(posedge core_clk_in);
    check({drv, acq, hold, adc_on, iref}, 8'h00);
    #1 rstn_in = 1'b1;
    repeat (5) @(posedge core_clk_in);
    // The first byte clears the reference power bit; code 4 ends the keep-on run.
    for (int s = 1; s >= 0; s--) begin
      for (int c = 0; c < 8; c++) begin
        conv(c[2:0], s[0], c == 7, c[0], c == 3);
        $display("test code %0d single_ended %0d done", c, s);
      end
    end
    ob = 8'hD1;
    for (int i = 7; i >= 0; i--) u_host.clk_bit(ob[i]);
    repeat (3) u_host.clk_bit(1'b0);
    u_host.clk_bit(1'b1);
    check(8'(hold), 8'h00);
    check(8'(drv), 8'h0C);
    u_host.deselect();
    repeat (8) @(posedge core_clk_in);
    check(8'({acq, hold, adc_on}), 8'h00);
    // Deselect powers the converter down but the keep-on bit holds the X drivers.
    check(8'(drv), 8'h0C);
    $display("test overlap and deselect done");
    give_verdict();
  end
endmodule : tb_touch_adc_input_mux_ref_control
